// File: design/vee_consts.svh
// Constants for the virtual event engine: offsets, fields, reset values, waiter codes
`ifndef VEE_CONSTS_SVH
`define VEE_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define VEE_REG_CTRL      4'h0
`define VEE_REG_STATUS    4'h4
`define VEE_REG_OVF_COUNT 4'h8
`define VEE_REG_RESULT    4'hC

`define VEE_CTRL_EN_BIT   0
`define VEE_CTRL_INH_BIT  1
`define VEE_CTRL_RST      2'h1

// ----------------------------------------
// Event and queue layout
// ----------------------------------------
`define VEE_READY_BIT     0
`define VEE_QUEUE_BIT     1
`define VEE_WORD1_OFS     32'h4
`define VEE_QFRONT_OFS    32'h4
`define VEE_QARRAY_OFS    32'h8

// ----------------------------------------
// Waiter codes held in the first word
// ----------------------------------------
`define VEE_W_CPU_IRQ     32'hFFFFFFFF
`define VEE_W_THREAD      32'hFFFFFFFE
`define VEE_W_DMA         32'hFFFFFFFD
`define VEE_W_NULL        32'hFFFFFFFC

`endif

// File: design/vee_pkg.sv
// Types shared by the virtual event engine
package vee_pkg;

  typedef enum logic [2:0] {
    VEE_OP_WAIT_LOCAL,
    VEE_OP_WAIT_REMOTE,
    VEE_OP_SET,
    VEE_OP_CLEAR,
    VEE_OP_TEST
  } vee_op_e;

  typedef enum logic [2:0] {
    VEE_EXC_NONE,
    VEE_EXC_QUEUE_OVERFLOW,
    VEE_EXC_PERMISSION,
    VEE_EXC_ALIGN,
    VEE_EXC_NULL_PROC
  } vee_exc_e;

  typedef enum logic [1:0] {
    VEE_DSP_RUN,
    VEE_DSP_REPLY,
    VEE_DSP_DMA
  } vee_dsp_e;

  typedef enum logic [4:0] {
    VEE_ST_IDLE,
    VEE_ST_EV0,
    VEE_ST_EV1,
    VEE_ST_EXEC,
    VEE_ST_QSIZE,
    VEE_ST_QFRONT,
    VEE_ST_QPLAN,
    VEE_ST_QENT0,
    VEE_ST_QENT1,
    VEE_ST_WR_ENT0,
    VEE_ST_WR_ENT1,
    VEE_ST_WR_FRONT,
    VEE_ST_WR_CNT,
    VEE_ST_WR_EV0,
    VEE_ST_WR_EV1,
    VEE_ST_DISPATCH,
    VEE_ST_DONE
  } vee_st_e;

  typedef struct packed {
    logic        valid;
    vee_op_e     op;
    logic        remote;
    logic [31:0] addr;
    logic [31:0] arg0;
    logic [31:0] arg1;
  } vee_op_s;

  typedef struct packed {
    logic        valid;
    logic        ready;
    logic        waiter;
    logic        cont;
    vee_exc_e    exc;
  } vee_res_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        lock;
    logic [31:0] addr;
    logic [31:0] wdata;
  } vee_mem_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } vee_mem_rsp_s;

  typedef struct packed {
    logic        valid;
    vee_dsp_e    kind;
    logic        irq;
    logic [31:0] w0;
    logic [31:0] w1;
  } vee_dsp_s;

  typedef struct packed {
    vee_st_e     st;
    vee_op_e     op;
    logic        remote;
    logic        wake;
    logic [31:0] ev_addr;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] qsize;
    logic [31:0] qfront;
    logic [31:0] ent_addr;
    logic [31:0] ent0;
    logic [31:0] ent1;
    vee_mem_s    mem;
    vee_dsp_s    dsp;
    vee_res_s    res;
    logic [1:0]  ctrl;
    logic [15:0] ovf_cnt;
    logic [31:0] rdata;
    logic        irq;
    logic [31:0] irq_addr;
  } vee_state_s;

endpackage

// File: design/vee_engine.sv
// Virtual event engine: atomic wait, set, clear and test on event words in memory
`timescale 1ns/10ps
`include "vee_consts.svh"

module vee_engine (
  input  wire logic                 MCLK,                     // 125 MHz clock
  input  wire logic                 RST_N,                    // Sync reset, active low
  input  wire vee_pkg::vee_op_s     OP_REQ,                   // Operation request
  output logic                      OP_READY,                 // Request taken when high
  input  wire logic                 LOCAL_SIGNAL_PERMISSION,  // Page allows local events
  input  wire logic                 REMOTE_SIGNAL_PERMISSION, // Page allows remote events
  output vee_pkg::vee_res_s         OP_RES,                   // Completion pulse and result
  output vee_pkg::vee_mem_s         MEM_REQ,                  // Memory bus request
  input  wire vee_pkg::vee_mem_rsp_s MEM_RSP,                 // Memory bus answer
  output vee_pkg::vee_dsp_s         DSP,                      // Woken waiter to queues
  input  wire logic                 DSP_READY,                // Target queue accepts
  input  wire logic                 IRQ_FRONT_VALID,          // Processor waiter at front
  input  wire logic [31:0]          IRQ_FRONT_ADDR,           // Its interrupt address
  output logic                      CPU_IRQ,                  // Interrupt pulse
  output logic [31:0]               CPU_IRQ_ADDR,             // Interrupt address
  input  wire logic [3:0]           REG_ADDR,                 // Register byte address
  input  wire logic [31:0]          REG_WDATA,                // Register write data
  input  wire logic                 REG_WR,                   // Register write strobe
  input  wire logic                 REG_RD,                   // Register read strobe
  output logic [31:0]               REG_RDATA                 // Read data, next cycle
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  vee_pkg::vee_state_s s_ff;
  vee_pkg::vee_state_s nxt_s;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic vee_pkg::vee_mem_s rd(input logic [31:0] a);
    vee_pkg::vee_mem_s m;
    m       = '0;
    m.req   = 1'b1;
    m.addr  = a;
    return m;
  endfunction

  function automatic vee_pkg::vee_mem_s wr(input logic [31:0] a, input logic [31:0] d);
    vee_pkg::vee_mem_s m;
    m       = '0;
    m.req   = 1'b1;
    m.we    = 1'b1;
    m.addr  = a;
    m.wdata = d;
    return m;
  endfunction

  function automatic logic [31:0] ent_at(input logic [31:0] qb, input logic [31:0] idx);
    return qb + `VEE_QARRAY_OFS + {idx[28:0], 3'h0};
  endfunction

  function automatic vee_pkg::vee_state_s fail(input vee_pkg::vee_state_s t,
                                               input vee_pkg::vee_exc_e c);
    vee_pkg::vee_state_s r;
    r         = t;
    r.res.exc = c;
    r.st      = vee_pkg::VEE_ST_DONE;
    r.mem     = '0;
    r.wake    = 1'b0;
    if (c == vee_pkg::VEE_EXC_QUEUE_OVERFLOW) begin
      r.ovf_cnt = t.ovf_cnt + 16'h0001;
    end
    return r;
  endfunction

  // Hand a waiter to the right queue by its first-word code
  function automatic vee_pkg::vee_state_s wake(input vee_pkg::vee_state_s t,
                                               input logic [31:0] d0,
                                               input logic [31:0] d1);
    vee_pkg::vee_state_s r;
    r           = t;
    r.wake      = 1'b0;
    r.mem       = '0;
    r.dsp.w0    = d0;
    r.dsp.w1    = d1;
    r.dsp.irq   = 1'b0;
    r.st        = vee_pkg::VEE_ST_DISPATCH;
    r.dsp.valid = 1'b1;
    if (d0 == `VEE_W_CPU_IRQ) begin
      r.dsp.kind = vee_pkg::VEE_DSP_RUN;
      r.dsp.irq  = 1'b1;
    end else if (d0 == `VEE_W_THREAD) begin
      r.dsp.kind = vee_pkg::VEE_DSP_RUN;
    end else if (d0 == `VEE_W_DMA) begin
      r.dsp.kind = vee_pkg::VEE_DSP_DMA;
    end else if (d0 == `VEE_W_NULL) begin
      r.dsp.valid = 1'b0;
      r.st        = vee_pkg::VEE_ST_DONE;
    end else if ($signed(d0) < $signed(`VEE_W_NULL)) begin
      // Local event waiter: chain a local set onto it, still under lock
      r.dsp.valid = 1'b0;
      if (d1[2:0] != 3'h0) begin
        r = fail(r, vee_pkg::VEE_EXC_ALIGN);
      end else begin
        r.op      = vee_pkg::VEE_OP_SET;
        r.remote  = 1'b0;
        r.ev_addr = d1;
        r.st      = vee_pkg::VEE_ST_EV0;
        r.mem     = rd(d1);
      end
    end else begin
      r.dsp.kind = vee_pkg::VEE_DSP_REPLY;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic        rdy;
    logic        hasq;
    logic        waiting;
    logic        ack;
    logic        perm_ok;
    logic [31:0] qbase;
    logic [31:0] wait_w0;
    logic [31:0] slot;
    logic [31:0] nfront;
    logic [31:0] ncnt;
    rdy     = s_ff.w1[`VEE_READY_BIT];
    hasq    = s_ff.w1[`VEE_QUEUE_BIT];
    waiting = |s_ff.w1[31:2];
    ack     = s_ff.mem.req && MEM_RSP.ack;
    qbase   = {s_ff.w1[31:2], 2'h0};
    wait_w0 = (s_ff.op == vee_pkg::VEE_OP_WAIT_LOCAL) ? `VEE_W_THREAD : s_ff.arg0;
    slot    = s_ff.qfront + s_ff.w0;
    nfront  = s_ff.qfront + 32'h1;
    ncnt    = s_ff.w0 - 32'h1;
    perm_ok = 1'b0;

    nxt_s           = s_ff;
    nxt_s.res.valid = 1'b0;
    nxt_s.irq       = 1'b0;
    nxt_s.rdata     = 32'h0;

    // Register port
    if (REG_WR && REG_ADDR == `VEE_REG_CTRL) begin
      nxt_s.ctrl = REG_WDATA[1:0];
    end
    if (REG_RD) begin
      if (REG_ADDR == `VEE_REG_CTRL) begin
        nxt_s.rdata = {30'h0, s_ff.ctrl};
      end else if (REG_ADDR == `VEE_REG_STATUS) begin
        nxt_s.rdata = {25'h0, s_ff.res.exc, 2'h0, s_ff.mem.lock,
                       s_ff.st != vee_pkg::VEE_ST_IDLE};
      end else if (REG_ADDR == `VEE_REG_OVF_COUNT) begin
        nxt_s.rdata = {16'h0, s_ff.ovf_cnt};
      end else if (REG_ADDR == `VEE_REG_RESULT) begin
        nxt_s.rdata = {29'h0, s_ff.res.cont, s_ff.res.waiter, s_ff.res.ready};
      end
    end

    // Processor waiter reached the run queue front
    if (IRQ_FRONT_VALID) begin
      nxt_s.irq      = 1'b1;
      nxt_s.irq_addr = IRQ_FRONT_ADDR;
    end

    case (s_ff.st)
      vee_pkg::VEE_ST_IDLE: begin
        if (OP_REQ.valid && OP_READY) begin
          nxt_s.op      = OP_REQ.op;
          nxt_s.remote  = OP_REQ.remote;
          nxt_s.ev_addr = OP_REQ.addr;
          nxt_s.arg0    = OP_REQ.arg0;
          nxt_s.arg1    = OP_REQ.arg1;
          nxt_s.wake    = 1'b0;
          nxt_s.res     = '0;
          if (OP_REQ.remote) begin
            perm_ok = REMOTE_SIGNAL_PERMISSION &&
                      (OP_REQ.op == vee_pkg::VEE_OP_SET ||
                       OP_REQ.op == vee_pkg::VEE_OP_WAIT_REMOTE ||
                       OP_REQ.op == vee_pkg::VEE_OP_TEST);
          end else begin
            perm_ok = LOCAL_SIGNAL_PERMISSION;
          end
          if (!perm_ok) begin
            nxt_s = fail(nxt_s, vee_pkg::VEE_EXC_PERMISSION);
          end else if (OP_REQ.addr[2:0] != 3'h0) begin
            nxt_s = fail(nxt_s, vee_pkg::VEE_EXC_ALIGN);
          end else if (OP_REQ.op == vee_pkg::VEE_OP_WAIT_REMOTE && OP_REQ.arg0 == 32'h0) begin
            nxt_s = fail(nxt_s, vee_pkg::VEE_EXC_NULL_PROC);
          end else begin
            nxt_s.st  = vee_pkg::VEE_ST_EV0;
            nxt_s.mem = rd(OP_REQ.addr);
          end
        end
      end
      vee_pkg::VEE_ST_EV0: begin
        if (ack) begin
          nxt_s.w0  = MEM_RSP.rdata;
          nxt_s.st  = vee_pkg::VEE_ST_EV1;
          nxt_s.mem = rd(s_ff.ev_addr + `VEE_WORD1_OFS);
        end
      end
      vee_pkg::VEE_ST_EV1: begin
        if (ack) begin
          nxt_s.w1  = MEM_RSP.rdata;
          nxt_s.st  = vee_pkg::VEE_ST_EXEC;
          nxt_s.mem = '0;
        end
      end
      vee_pkg::VEE_ST_EXEC: begin
        nxt_s.res.ready  = rdy;
        nxt_s.res.waiter = s_ff.w0 != 32'h0;
        case (s_ff.op)
          vee_pkg::VEE_OP_TEST: begin
            nxt_s.st = vee_pkg::VEE_ST_DONE;
          end
          vee_pkg::VEE_OP_CLEAR: begin
            nxt_s.w1[`VEE_READY_BIT] = 1'b0;
            nxt_s.st  = vee_pkg::VEE_ST_WR_EV1;
            nxt_s.mem = wr(s_ff.ev_addr + `VEE_WORD1_OFS, nxt_s.w1);
          end
          vee_pkg::VEE_OP_SET: begin
            if ((hasq && s_ff.w0 == 32'h0) || (!hasq && !waiting)) begin
              nxt_s.w1[`VEE_READY_BIT] = 1'b1;
              nxt_s.st  = vee_pkg::VEE_ST_WR_EV1;
              nxt_s.mem = wr(s_ff.ev_addr + `VEE_WORD1_OFS, nxt_s.w1);
            end else if (hasq) begin
              nxt_s.st  = vee_pkg::VEE_ST_QSIZE;
              nxt_s.mem = rd(qbase);
            end else begin
              nxt_s.ent0 = s_ff.w0;
              nxt_s.ent1 = s_ff.w1;
              nxt_s.w0   = 32'h0;
              nxt_s.w1   = 32'h0;
              nxt_s.wake = 1'b1;
              nxt_s.st   = vee_pkg::VEE_ST_WR_EV0;
              nxt_s.mem  = wr(s_ff.ev_addr, 32'h0);
            end
          end
          default: begin
            if (rdy) begin
              nxt_s.w1[`VEE_READY_BIT] = 1'b0;
              nxt_s.res.cont = s_ff.op == vee_pkg::VEE_OP_WAIT_LOCAL;
              if (s_ff.op == vee_pkg::VEE_OP_WAIT_REMOTE) begin
                nxt_s.wake = 1'b1;
                nxt_s.ent0 = s_ff.arg0;
                nxt_s.ent1 = s_ff.arg1;
              end
              nxt_s.st  = vee_pkg::VEE_ST_WR_EV1;
              nxt_s.mem = wr(s_ff.ev_addr + `VEE_WORD1_OFS, nxt_s.w1);
            end else if (!hasq) begin
              if (waiting) begin
                nxt_s = fail(nxt_s, vee_pkg::VEE_EXC_QUEUE_OVERFLOW);
              end else begin
                nxt_s.w0  = wait_w0;
                nxt_s.w1  = s_ff.arg1;
                nxt_s.st  = vee_pkg::VEE_ST_WR_EV0;
                nxt_s.mem = wr(s_ff.ev_addr, wait_w0);
              end
            end else begin
              nxt_s.st  = vee_pkg::VEE_ST_QSIZE;
              nxt_s.mem = rd(qbase);
            end
          end
        endcase
      end
      vee_pkg::VEE_ST_QSIZE: begin
        if (ack) begin
          nxt_s.qsize = MEM_RSP.rdata;
          nxt_s.st    = vee_pkg::VEE_ST_QFRONT;
          nxt_s.mem   = rd(qbase + `VEE_QFRONT_OFS);
        end
      end
      vee_pkg::VEE_ST_QFRONT: begin
        if (ack) begin
          nxt_s.qfront = MEM_RSP.rdata;
          if (s_ff.op == vee_pkg::VEE_OP_SET) begin
            nxt_s.ent_addr = ent_at(qbase, MEM_RSP.rdata);
            nxt_s.st       = vee_pkg::VEE_ST_QENT0;
            nxt_s.mem      = rd(ent_at(qbase, MEM_RSP.rdata));
          end else begin
            nxt_s.st  = vee_pkg::VEE_ST_QPLAN;
            nxt_s.mem = '0;
          end
        end
      end
      vee_pkg::VEE_ST_QPLAN: begin
        if (s_ff.w0 >= s_ff.qsize) begin
          nxt_s = fail(nxt_s, vee_pkg::VEE_EXC_QUEUE_OVERFLOW);
        end else begin
          if (s_ff.w0 == 32'h0) begin
            nxt_s.qfront = 32'h0;
            slot         = 32'h0;
          end else if (slot >= s_ff.qsize) begin
            slot = slot - s_ff.qsize;
          end
          nxt_s.w0       = s_ff.w0 + 32'h1;
          nxt_s.ent_addr = ent_at(qbase, slot);
          nxt_s.st       = vee_pkg::VEE_ST_WR_ENT0;
          nxt_s.mem      = wr(ent_at(qbase, slot), wait_w0);
        end
      end
      vee_pkg::VEE_ST_WR_ENT0: begin
        if (ack) begin
          nxt_s.st  = vee_pkg::VEE_ST_WR_ENT1;
          nxt_s.mem = wr(s_ff.ent_addr + `VEE_WORD1_OFS, s_ff.arg1);
        end
      end
      vee_pkg::VEE_ST_WR_ENT1: begin
        if (ack) begin
          nxt_s.st  = vee_pkg::VEE_ST_WR_FRONT;
          nxt_s.mem = wr(qbase + `VEE_QFRONT_OFS, s_ff.qfront);
        end
      end
      vee_pkg::VEE_ST_QENT0: begin
        if (ack) begin
          nxt_s.ent0 = MEM_RSP.rdata;
          nxt_s.st   = vee_pkg::VEE_ST_QENT1;
          nxt_s.mem  = rd(s_ff.ent_addr + `VEE_WORD1_OFS);
        end
      end
      vee_pkg::VEE_ST_QENT1: begin
        if (ack) begin
          nxt_s.ent1 = MEM_RSP.rdata;
          if (ncnt == 32'h0 || nfront >= s_ff.qsize) begin
            nfront = 32'h0;
          end
          nxt_s.qfront = nfront;
          nxt_s.w0     = ncnt;
          nxt_s.st     = vee_pkg::VEE_ST_WR_FRONT;
          nxt_s.mem    = wr(qbase + `VEE_QFRONT_OFS, nfront);
        end
      end
      vee_pkg::VEE_ST_WR_FRONT: begin
        if (ack) begin
          nxt_s.st  = vee_pkg::VEE_ST_WR_CNT;
          nxt_s.mem = wr(s_ff.ev_addr, s_ff.w0);
        end
      end
      vee_pkg::VEE_ST_WR_CNT: begin
        if (ack) begin
          if (s_ff.op != vee_pkg::VEE_OP_SET) begin
            nxt_s.st  = vee_pkg::VEE_ST_DONE;
            nxt_s.mem = '0;
          end else if (s_ff.ent0 == 32'h0 && s_ff.ent1 == 32'h0) begin
            if (s_ff.w0 != 32'h0) begin
              nxt_s.ent_addr = ent_at(qbase, s_ff.qfront);
              nxt_s.st       = vee_pkg::VEE_ST_QENT0;
              nxt_s.mem      = rd(ent_at(qbase, s_ff.qfront));
            end else begin
              nxt_s.w1[`VEE_READY_BIT] = 1'b1;
              nxt_s.st  = vee_pkg::VEE_ST_WR_EV1;
              nxt_s.mem = wr(s_ff.ev_addr + `VEE_WORD1_OFS, nxt_s.w1);
            end
          end else begin
            nxt_s = wake(nxt_s, s_ff.ent0, s_ff.ent1);
          end
        end
      end
      vee_pkg::VEE_ST_WR_EV0: begin
        if (ack) begin
          nxt_s.st  = vee_pkg::VEE_ST_WR_EV1;
          nxt_s.mem = wr(s_ff.ev_addr + `VEE_WORD1_OFS, s_ff.w1);
        end
      end
      vee_pkg::VEE_ST_WR_EV1: begin
        if (ack) begin
          if (s_ff.wake) begin
            nxt_s = wake(nxt_s, s_ff.ent0, s_ff.ent1);
          end else begin
            nxt_s.st  = vee_pkg::VEE_ST_DONE;
            nxt_s.mem = '0;
          end
        end
      end
      vee_pkg::VEE_ST_DISPATCH: begin
        if (DSP_READY) begin
          nxt_s.dsp.valid = 1'b0;
          nxt_s.st        = vee_pkg::VEE_ST_DONE;
        end
      end
      vee_pkg::VEE_ST_DONE: begin
        nxt_s.res.valid = 1'b1;
        nxt_s.st        = vee_pkg::VEE_ST_IDLE;
      end
      default: begin
        nxt_s.st  = vee_pkg::VEE_ST_IDLE;
        nxt_s.mem = '0;
      end
    endcase

    // Lock spans the whole read-modify-write so queue edits stay atomic
    nxt_s.mem.lock = nxt_s.st != vee_pkg::VEE_ST_IDLE;
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      s_ff      <= '0;
      s_ff.ctrl <= `VEE_CTRL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Inhibit holds off new work only; an operation in flight completes
  assign OP_READY     = s_ff.st == vee_pkg::VEE_ST_IDLE && s_ff.ctrl[`VEE_CTRL_EN_BIT] &&
                        !s_ff.ctrl[`VEE_CTRL_INH_BIT];
  assign OP_RES       = s_ff.res;
  assign MEM_REQ      = s_ff.mem;
  assign DSP          = s_ff.dsp;
  assign CPU_IRQ      = s_ff.irq;
  assign CPU_IRQ_ADDR = s_ff.irq_addr;
  assign REG_RDATA    = s_ff.rdata;

endmodule

// File: tb/vee_mem_model.sv
// Main memory standing behind the event engine; it ignores the bus lock
`timescale 1ns/10ps
module vee_mem_model (
  input  wire logic                  clk,   // Clock
  input  wire logic                  stall, // Hold the answer back
  input  wire vee_pkg::vee_mem_s     req,   // Engine access
  output vee_pkg::vee_mem_rsp_s      rsp    // Answer
);
  logic [31:0] m [0:255];
  logic        go;

  assign go = req.req && !rsp.ack && !stall;

  // Word addressing keeps double-word pairs at even indices
  always @(posedge clk) begin
    rsp.ack <= go;
    if (go) begin
      rsp.rdata <= m[req.addr[9:2]];
      if (req.we)
        m[req.addr[9:2]] <= req.wdata;
    end else
      rsp.rdata <= ~rsp.rdata; // Idle bus shows junk, and the old word again every second cycle
  end
endmodule

// File: tb/vee_engine_sva.sv
// Port assertions for the virtual event engine
`timescale 1ns/10ps
module vee_engine_sva (
  input wire logic                  MCLK,                     // Clock
  input wire logic                  RST_N,                    // Reset
  input wire vee_pkg::vee_op_s      OP_REQ,                   // Request
  input wire logic                  OP_READY,                 // Take
  input wire logic                  REMOTE_SIGNAL_PERMISSION, // Rights
  input wire vee_pkg::vee_res_s     OP_RES,                   // Result
  input wire vee_pkg::vee_mem_s     MEM_REQ,                  // Bus out
  input wire vee_pkg::vee_mem_rsp_s MEM_RSP,                  // Bus in
  input wire vee_pkg::vee_dsp_s     DSP,                      // Wake
  input wire logic                  DSP_READY,                // Accept
  input wire logic                  IRQ_FRONT_VALID,          // Front
  input wire logic [31:0]           IRQ_FRONT_ADDR,           // Front addr
  input wire logic                  CPU_IRQ,                  // Irq
  input wire logic [31:0]           CPU_IRQ_ADDR              // Irq addr
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_lock_on_access: assert property (MEM_REQ.req |-> MEM_REQ.lock)
    else $error("access without bus lock");
  a_req_held: assert property (MEM_REQ.req && !MEM_RSP.ack |=> MEM_REQ.req && $stable(MEM_REQ))
    else $error("access dropped before answer");
  a_lock_busy: assert property (MEM_REQ.lock |-> !OP_READY)
    else $error("new request open under lock");
  a_irq_follows: assert property (IRQ_FRONT_VALID |=> CPU_IRQ && CPU_IRQ_ADDR == $past(IRQ_FRONT_ADDR))
    else $error("front waiter not signalled");
  a_irq_only_front: assert property (!IRQ_FRONT_VALID |=> !CPU_IRQ)
    else $error("interrupt without front waiter");
  a_cpu_via_run: assert property (DSP.valid && DSP.irq |-> DSP.kind == vee_pkg::VEE_DSP_RUN)
    else $error("processor waiter off run queue");
  a_wake_held: assert property (DSP.valid && !DSP_READY |=> DSP.valid && $stable(DSP))
    else $error("wake dropped before accept");
  a_remote_denied: assert property (OP_REQ.valid && OP_READY && OP_REQ.remote && !REMOTE_SIGNAL_PERMISSION
    |=> !MEM_REQ.req ##1 OP_RES.valid && OP_RES.exc == vee_pkg::VEE_EXC_PERMISSION)
    else $error("remote access without rights");
endmodule

bind vee_engine vee_engine_sva u_sva (.MCLK(MCLK), .RST_N(RST_N), .OP_REQ(OP_REQ),
  .OP_READY(OP_READY), .REMOTE_SIGNAL_PERMISSION(REMOTE_SIGNAL_PERMISSION), .OP_RES(OP_RES),
  .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP), .DSP(DSP), .DSP_READY(DSP_READY),
  .IRQ_FRONT_VALID(IRQ_FRONT_VALID), .IRQ_FRONT_ADDR(IRQ_FRONT_ADDR), .CPU_IRQ(CPU_IRQ),
  .CPU_IRQ_ADDR(CPU_IRQ_ADDR));

// File: tb/vee_engine_tb.sv
// Self-checking bench for the virtual event engine
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module vee_engine_tb;
  logic                  mclk = 1'b0, rst_n = 1'b0, dsp_ready = 1'b0, stall = 1'b0;
  logic                  ifv = 1'b0, rp = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic                  op_ready, cpu_irq;
  logic [3:0]            reg_addr = 4'h0;
  logic [31:0]           reg_wdata = 32'h0, ifa = 32'h0, reg_rdata, cpu_irq_addr, w0, w1;
  vee_pkg::vee_op_s      op_req = '0;
  vee_pkg::vee_res_s     op_res;
  vee_pkg::vee_mem_s     mem_req;
  vee_pkg::vee_mem_rsp_s mem_rsp;
  vee_pkg::vee_dsp_s     dsp, got;
  int                    bad_count = 0, tests_run = 0, n_dsp = 0, d0 = 0, seed = 32'hD8E11D17;

  vee_engine uut (.MCLK(mclk), .RST_N(rst_n), .OP_REQ(op_req), .OP_READY(op_ready),
    .LOCAL_SIGNAL_PERMISSION(1'b1), .REMOTE_SIGNAL_PERMISSION(rp), .OP_RES(op_res),
    .MEM_REQ(mem_req), .MEM_RSP(mem_rsp), .DSP(dsp), .DSP_READY(dsp_ready),
    .IRQ_FRONT_VALID(ifv), .IRQ_FRONT_ADDR(ifa), .CPU_IRQ(cpu_irq), .CPU_IRQ_ADDR(cpu_irq_addr),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata));
  vee_mem_model mem (.clk(mclk), .stall(stall), .req(mem_req), .rsp(mem_rsp));

  initial forever #4 mclk = ~mclk;
  // Random stalls on both far sides
  always @(posedge mclk) begin
    dsp_ready <= 1'($random(seed));
    stall <= 1'($random(seed));
    if (dsp.valid && dsp_ready) begin
      got <= dsp;
      n_dsp <= n_dsp + 1;
    end
  end

  function automatic logic [1:0] test_exp(input logic [31:0] a, b);
    return {a != 32'h0, b[0]};
  endfunction

  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic reg_io(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask

  task automatic setev(input logic [31:0] a, b);
    mem.m[4] = a;
    mem.m[5] = b;
  endtask

  // Event always at 0x10; a slow answer counts as a hang
  task automatic do_op(input vee_pkg::vee_op_e op, input logic rem, p, input logic [31:0] a0, a1);
    int n;
    d0 = n_dsp;
    n = 0;
    @(posedge mclk);
    op_req <= {1'b1, op, rem, 32'h10, a0, a1};
    rp <= p;
    do begin
      @(negedge mclk);
      n++;
    end while (!op_ready && n < 99);
    @(posedge mclk);
    op_req.valid <= 1'b0;
    while (!op_res.valid && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    reg_io(0, 4'h0, 0);
    `CHK(reg_rdata, 32'h1)
    reg_io(0, 4'h2, 0);
    `CHK(reg_rdata, 32'h0)
    repeat (6) begin
      w0 = ($random(seed) & 1) ? 32'h0 : $random(seed);
      w1 = $random(seed);
      setev(w0, w1);
      do_op(vee_pkg::VEE_OP_TEST, 0, 1, 0, 0);
      `CHK({op_res.waiter, op_res.ready}, test_exp(w0, w1))
      setev(w0, 32'h0);
      do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
      `CHK({mem.m[4], mem.m[5]}, {w0, 32'h1})
    end
    do_op(vee_pkg::VEE_OP_WAIT_LOCAL, 0, 1, 0, 32'h200);
    `CHK({op_res.cont, mem.m[5]}, {1'b1, 32'h0})
    do_op(vee_pkg::VEE_OP_WAIT_LOCAL, 0, 1, 0, 32'h200);
    `CHK({mem.m[4], mem.m[5]}, {32'hFFFFFFFE, 32'h200})
    do_op(vee_pkg::VEE_OP_WAIT_LOCAL, 0, 1, 0, 32'h200);
    `CHK(op_res.exc, vee_pkg::VEE_EXC_QUEUE_OVERFLOW)
    reg_io(0, 4'h8, 0);
    `CHK(reg_rdata, 32'h1)
    do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
    `CHK({mem.m[4], mem.m[5], got.kind, got.w1}, {64'h0, vee_pkg::VEE_DSP_RUN, 32'h200})
    setev(32'hFFFFFFFF, 32'h300);
    do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
    `CHK({got.irq, got.kind}, {1'b1, vee_pkg::VEE_DSP_RUN})
    w1 = $random(seed);
    @(posedge mclk);
    ifv <= 1'b1;
    ifa <= w1;
    @(posedge mclk);
    ifv <= 1'b0;
    #1 `CHK({cpu_irq, cpu_irq_addr}, {1'b1, w1})
    do_op(vee_pkg::VEE_OP_WAIT_REMOTE, 1, 1, 0, 32'h400);
    `CHK(op_res.exc, vee_pkg::VEE_EXC_NULL_PROC)
    setev(32'h0, 32'h1);
    do_op(vee_pkg::VEE_OP_WAIT_REMOTE, 1, 1, 32'h7, 32'h400);
    `CHK({got.kind, got.w0, got.w1, mem.m[5]}, {vee_pkg::VEE_DSP_REPLY, 32'h7, 32'h400, 32'h0})
    do_op(vee_pkg::VEE_OP_SET, 1, 0, 0, 0);
    `CHK(op_res.exc, vee_pkg::VEE_EXC_PERMISSION)
    do_op(vee_pkg::VEE_OP_CLEAR, 1, 1, 0, 0);
    `CHK(op_res.exc, vee_pkg::VEE_EXC_PERMISSION)
    setev(32'h5, 32'h1);
    do_op(vee_pkg::VEE_OP_CLEAR, 0, 1, 0, 0);
    `CHK({mem.m[4], mem.m[5]}, {32'h5, 32'h0})
    reg_io(0, 4'hC, 0);
    `CHK(reg_rdata, 32'h3)
    reg_io(1, 4'h0, 32'h3);
    `CHK(op_ready, 1'b0)
    setev(32'h0, 32'h42);
    mem.m[16] = 32'h1;
    mem.m[17] = 32'h5;
    reg_io(1, 4'h0, 32'h1);
    do_op(vee_pkg::VEE_OP_WAIT_LOCAL, 0, 1, 0, 32'h500);
    `CHK({mem.m[4], mem.m[17], mem.m[19]}, {32'h1, 32'h0, 32'h500})
    do_op(vee_pkg::VEE_OP_WAIT_LOCAL, 0, 1, 0, 32'h500);
    `CHK(op_res.exc, vee_pkg::VEE_EXC_QUEUE_OVERFLOW)
    do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
    `CHK({mem.m[4], got.w1, n_dsp - d0}, {32'h0, 32'h500, 32'h1})
    mem.m[4] = 32'h1;
    mem.m[18] = 32'h0;
    mem.m[19] = 32'h0;
    do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
    `CHK({mem.m[5], n_dsp - d0}, {32'h43, 32'h0})
    setev(32'hFFFFFFFD, 32'h600);
    do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
    `CHK({got.kind, got.w1, n_dsp - d0}, {vee_pkg::VEE_DSP_DMA, 32'h600, 32'h1})
    setev(32'hFFFFFFFC, 32'h8);
    do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
    `CHK({mem.m[4], mem.m[5], n_dsp - d0}, {64'h0, 32'h0})
    // Local event waiter: the set is passed on to the event it names
    mem.m[8] = 32'h0;
    mem.m[9] = 32'h0;
    setev(32'hFFFFFFF0, 32'h20);
    do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
    `CHK({mem.m[5], mem.m[9], n_dsp - d0}, {32'h0, 32'h1, 32'h0})
    setev(32'hFFFFFFF0, 32'h24);
    do_op(vee_pkg::VEE_OP_SET, 0, 1, 0, 0);
    `CHK(op_res.exc, vee_pkg::VEE_EXC_ALIGN)
    tally_and_finish();
  end
endmodule
